// ### i2c_abort_defs.svh
`ifndef I2C_ABORT_DEFS_SVH
`define I2C_ABORT_DEFS_SVH
// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define TIMEOUT_CTRL_OFS   8'h7c
`define ABORT_CAUSE_OFS    8'h80
`define ABORT_RESET        16'h0000
`define TIMEOUT_EN_BIT     0
`define TIMEOUT_CNT_LSB    4
// ----------------------------------------------------------------
// Abort cause bit positions
// ----------------------------------------------------------------
`define AB_SEVENBIT_NACK   0
`define AB_TENBIT1_NACK    1
`define AB_TENBIT2_NACK    2
`define AB_DATA_NACK       3
`define AB_GENCALL_NACK    4
`define AB_GENCALL_READ    5
`define AB_HS_ACKED        6
`define AB_SB_ACKED        7
`define AB_HS_NORESTART    8
`define AB_SB_NORESTART    9
`define AB_TENRD_NORESTART 10
`define AB_MASTER_DIS      11
`define AB_ARB_LOST        12
`define AB_SLV_FLUSH       13
`define AB_SLV_ARB_LOST    14
`define AB_SLV_REQ_TX      15
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define TIMEOUT_PERIODS    256
`define ACK_BIT_INDEX      4'h9
`endif

// ### i2c_abort_pkg.sv
`default_nettype none
// ----------------------------------------------------------------
// Types
// ----------------------------------------------------------------
package i2c_abort_pkg;
   typedef enum logic [2:0] {
      KIND_ADDR7   = 3'b000,
      KIND_ADDR10A = 3'b001,
      KIND_ADDR10B = 3'b010,
      KIND_DATA    = 3'b011,
      KIND_GENCALL = 3'b100,
      KIND_HSCODE  = 3'b101,
      KIND_STARTB  = 3'b110,
      KIND_NONE    = 3'b111
   } byte_kind_e;
   typedef enum logic [1:0] {
      MON_IDLE = 2'b00,
      MON_BITS = 2'b01,
      MON_ACK  = 2'b10
   } mon_state_e;
endpackage : i2c_abort_pkg
`default_nettype wire

// ### i2c_transmit_abort_status.sv
// How it works
// - Slave read request with a read command queued sets slave_req_tx_abort.
// - Slave transmitter losing the bus sets slave_arb_lost.
// - Slave read request with stale transmit data sets slave_flush_tx.
// - Arbitration loss sets arb_lost_a; with slave_arb_lost it means slave side.
// - Master command while master function disabled sets master_disabled_abort.
// - Ten-bit read with restart disabled sets tenbit_read_no_restart.
// - Start byte request with restart disabled sets startbyte_no_restart.
// - High-speed master transfer with restart disabled sets highspeed_no_restart.
// - Acknowledged start byte sets startbyte_acked.
// - Acknowledged high-speed master code sets hs_code_acked.
// - Read queued right after a general call sets gencall_read.
// - Unacknowledged general call sets gencall_unacked.
// - Unacknowledged master data byte sets data_unacked.
// - Unacknowledged second ten-bit address byte sets tenbit_second_unacked.
// - Unacknowledged first ten-bit address byte sets tenbit_first_unacked.
// - Unacknowledged seven-bit address sets sevenbit_addr_unacked.
// - Sixteen flags in low half reset to zero; upper half reads zero.
// - With timeout_enable, master waits 256 periods for slave, then resets.
//
// Added by the designer: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "i2c_abort_defs.svh"

module i2c_transmit_abort_status
   import i2c_abort_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   input  wire logic [7:0]  regAddr,
   input  wire logic [31:0] regWrData,
   input  wire logic        regWr,
   input  wire logic        regRd,
   output logic      [31:0] regRdData,
   input  wire logic        sclIn,
   input  wire logic        sdaIn,
   input  wire logic        masterEnable,
   input  wire logic        restartEnable,
   input  wire logic        tenBitMode,
   input  wire logic        hsMode,
   input  wire logic        cmdPush,
   input  wire logic        cmdRead,
   input  wire logic        cmdStartByte,
   input  wire logic [2:0]  byteKind,
   input  wire logic        masterTx,
   input  wire logic        masterSdaRelease,
   input  wire logic        masterSclRelease,
   input  wire logic        slaveTx,
   input  wire logic        slaveSdaRelease,
   input  wire logic        slaveReadReq,
   input  wire logic        txFifoNotEmpty,
   input  wire logic        txHeadIsRead,
   output logic             abortActive,
   output logic             masterTimeoutReset
);

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   // Only the second stage and its delayed copy are read, never stage one.
   logic [1:0]  sclSync;
   logic [1:0]  sdaSync;
   logic        sclPrev;
   logic        sdaPrev;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         sclSync <= 2'h3;
         sdaSync <= 2'h3;
         sclPrev <= 1'b1;
         sdaPrev <= 1'b1;
      end else begin
         sclSync <= {sclSync[0], sclIn};
         sdaSync <= {sdaSync[0], sdaIn};
         sclPrev <= sclSync[1];
         sdaPrev <= sdaSync[1];
      end
   end

   wire         sclLine  = sclSync[1];
   wire         sdaLine  = sdaSync[1];
   wire         sclRise  = sclLine & ~sclPrev;
   wire         startCond = sclLine & sclPrev & sdaPrev & ~sdaLine;
   wire         stopCond  = sclLine & sclPrev & ~sdaPrev & sdaLine;

   // ----------------------------------------------------------------
   // Byte and acknowledge monitor
   // ----------------------------------------------------------------
   mon_state_e  monState;
   mon_state_e  next_monState;
   logic [3:0]  bitCnt;
   wire         ackSlot  = (monState == MON_ACK) & sclRise;
   wire         ackSeen  = ackSlot & ~sdaLine;
   wire         nackSeen = ackSlot & sdaLine;

   always_comb begin
      next_monState = monState;
      case (monState)
         MON_IDLE: if (startCond) next_monState = MON_BITS;
         MON_BITS: begin
            if (stopCond) next_monState = MON_IDLE;
            else if (sclRise && bitCnt == 4'h7) next_monState = MON_ACK;
         end
         MON_ACK: begin
            if (stopCond) next_monState = MON_IDLE;
            else if (sclRise) next_monState = MON_BITS;
         end
         default: next_monState = MON_IDLE;
      endcase
      if (startCond) next_monState = MON_BITS;
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         monState <= MON_IDLE;
         bitCnt   <= 4'h0;
      end else begin
         monState <= next_monState;
         if (startCond || ackSlot) bitCnt <= 4'h0;
         else if (sclRise && monState == MON_BITS) bitCnt <= bitCnt + 4'h1;
      end
   end

   // ----------------------------------------------------------------
   // Abort event decode
   // ----------------------------------------------------------------
   wire         mNack = nackSeen & masterTx;
   wire         mAck  = ackSeen & masterTx;
   wire         evAddr7  = mNack & (byteKind == KIND_ADDR7);
   wire         evTen1   = mNack & (byteKind == KIND_ADDR10A);
   wire         evTen2   = mNack & (byteKind == KIND_ADDR10B);
   wire         evData   = mNack & (byteKind == KIND_DATA);
   wire         evGcNack = mNack & (byteKind == KIND_GENCALL);
   wire         evHsAck  = mAck & hsMode & (byteKind == KIND_HSCODE);
   wire         evSbAck  = mAck & (byteKind == KIND_STARTB);
   wire         noRst    = cmdPush & ~restartEnable;
   wire         evHsNr   = noRst & hsMode;
   wire         evSbNr   = noRst & cmdStartByte;
   wire         evTenRd  = noRst & tenBitMode & cmdRead;
   wire         evMDis   = cmdPush & ~masterEnable;
   wire         mArb     = sclRise & masterTx & masterSdaRelease & ~sdaLine;
   wire         sArb     = sclRise & slaveTx & slaveSdaRelease & ~sdaLine;
   wire         evFlush  = slaveReadReq & txFifoNotEmpty;
   wire         evReqTx  = slaveReadReq & txHeadIsRead;

   // A general call that was acknowledged arms the read check for the next command
   logic        gcArmed;
   wire         evGcRd   = cmdPush & cmdRead & gcArmed;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) gcArmed <= 1'b0;
      else if (mAck && byteKind == KIND_GENCALL) gcArmed <= 1'b1;
      else if (cmdPush || stopCond) gcArmed <= 1'b0;
   end

   logic [15:0] events;
   always_comb begin
      events = 16'h0000;
      events[`AB_SEVENBIT_NACK]   = evAddr7;
      events[`AB_TENBIT1_NACK]    = evTen1;
      events[`AB_TENBIT2_NACK]    = evTen2;
      events[`AB_DATA_NACK]       = evData;
      events[`AB_GENCALL_NACK]    = evGcNack;
      events[`AB_GENCALL_READ]    = evGcRd;
      events[`AB_HS_ACKED]        = evHsAck;
      events[`AB_SB_ACKED]        = evSbAck;
      events[`AB_HS_NORESTART]    = evHsNr;
      events[`AB_SB_NORESTART]    = evSbNr;
      events[`AB_TENRD_NORESTART] = evTenRd;
      events[`AB_MASTER_DIS]      = evMDis;
      events[`AB_ARB_LOST]        = mArb | sArb;
      events[`AB_SLV_FLUSH]       = evFlush;
      events[`AB_SLV_ARB_LOST]    = sArb;
      events[`AB_SLV_REQ_TX]      = evReqTx;
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   wire         selAbort = (regAddr == `ABORT_CAUSE_OFS);
   wire         selTo    = (regAddr == `TIMEOUT_CTRL_OFS);
   logic [15:0] abortFlags;
   logic        timeoutEnable;
   logic [7:0]  toCount;
   // A cause that fires in the same cycle as a software clear stays set
   wire  [15:0] next_abortFlags = ((regWr && selAbort) ? regWrData[15:0] : abortFlags)
                                  | events;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         abortFlags    <= `ABORT_RESET;
         timeoutEnable <= 1'b0;
      end else begin
         abortFlags <= next_abortFlags;
         if (regWr && selTo) timeoutEnable <= regWrData[`TIMEOUT_EN_BIT];
      end
   end

   wire  [31:0] rdMux = selAbort ? {16'h0000, abortFlags} :
                        selTo    ? {20'h00000, toCount, 3'h0, timeoutEnable} :
                                   32'h00000000;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) regRdData <= 32'h00000000;
      else        regRdData <= regRd ? rdMux : 32'h00000000;
   end

   // ----------------------------------------------------------------
   // Master wait timeout
   // ----------------------------------------------------------------
   // Counts clock cycles while the master has let SCL go but a slave holds it low.
   // Works only for the master side; a slave stretching its own clock is not timed.
   localparam int unsigned ToLimit = `TIMEOUT_PERIODS - 1;
   wire         stretch = timeoutEnable & masterEnable & masterTx
                          & masterSclRelease & ~sclLine;
   wire         toHit   = stretch & (toCount == ToLimit[7:0]);
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         toCount            <= 8'h00;
         masterTimeoutReset <= 1'b0;
      end else begin
         toCount            <= (stretch && !toHit) ? toCount + 8'h01 : 8'h00;
         masterTimeoutReset <= toHit;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) abortActive <= 1'b0;
      else        abortActive <= |next_abortFlags;
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   AST_REQ_TX: assert property (evReqTx |=> abortFlags[`AB_SLV_REQ_TX])
      else $error("slave request flag not set");
   AST_SLV_ARB: assert property (sArb |=> abortFlags[`AB_SLV_ARB_LOST]
                                 && abortFlags[`AB_ARB_LOST])
      else $error("slave arbitration loss not recorded in both flags");
   AST_FLUSH: assert property (slaveReadReq && txFifoNotEmpty
                               |=> abortFlags[`AB_SLV_FLUSH])
      else $error("flush flag not set");
   AST_MDIS: assert property (cmdPush && !masterEnable |=> abortFlags[`AB_MASTER_DIS])
      else $error("master disabled flag missing");
   AST_TENRD: assert property (cmdPush && !restartEnable && tenBitMode && cmdRead
                               |=> abortFlags[`AB_TENRD_NORESTART])
      else $error("ten-bit read flag missing");
   AST_ADDR7: assert property (ackSlot && sdaLine && masterTx
                               && byteKind == KIND_ADDR7 |=> abortFlags[`AB_SEVENBIT_NACK])
      else $error("seven-bit nack flag missing");
   AST_DATA_NACK: assert property (ackSlot && sdaLine && masterTx
                                   && byteKind == KIND_DATA |=> abortFlags[`AB_DATA_NACK])
      else $error("data nack flag missing");
   AST_SB_ACK: assert property (ackSlot && !sdaLine && masterTx
                                && byteKind == KIND_STARTB |=> abortFlags[`AB_SB_ACKED])
      else $error("start byte ack flag missing");
   AST_HOLD: assert property (!(regWr && selAbort) && !(|events)
                              |=> abortFlags == $past(abortFlags))
      else $error("flags changed without cause");
   AST_UPPER: assert property ($past(regRd) && $past(selAbort)
                               |-> regRdData[31:16] == 16'h0000)
      else $error("reserved bits not zero");
   AST_TIMEOUT: assert property (toHit |=> masterTimeoutReset ##1 !masterTimeoutReset)
      else $error("timeout reset pulse wrong");
   AST_TO_NO_EN: assert property (!timeoutEnable |=> toCount == 8'h00)
      else $error("timeout counted while disabled");
   AST_TO_STEP: assert property (stretch && !toHit
                                 |=> toCount == $past(toCount) + 8'h01)
      else $error("timeout count did not advance");

   // ----------------------------------------------------------------
   // Set checks for the remaining causes, a slave-loss exclusion check and covers
   // ----------------------------------------------------------------
   // Ack-slot checks rely on byteKind standing still across the ninth SCL rise
   AST_TEN1: assert property (ackSlot && sdaLine && masterTx
                              && byteKind == KIND_ADDR10A |=> abortFlags[`AB_TENBIT1_NACK])
      else $error("first ten-bit nack flag missing");
   AST_TEN2: assert property (ackSlot && sdaLine && masterTx
                              && byteKind == KIND_ADDR10B |=> abortFlags[`AB_TENBIT2_NACK])
      else $error("second ten-bit nack flag missing");
   AST_GC_NACK: assert property (ackSlot && sdaLine && masterTx
                                 && byteKind == KIND_GENCALL |=> abortFlags[`AB_GENCALL_NACK])
      else $error("general call nack flag missing");
   AST_GC_READ: assert property (cmdPush && cmdRead && gcArmed
                                 |=> abortFlags[`AB_GENCALL_READ])
      else $error("general call read flag missing");
   AST_HS_ACK: assert property (ackSlot && !sdaLine && masterTx && hsMode
                                && byteKind == KIND_HSCODE |=> abortFlags[`AB_HS_ACKED])
      else $error("high-speed code ack flag missing");
   AST_HIGHSPEED_NO_RESTART: assert property (cmdPush && !restartEnable && hsMode
                              |=> abortFlags[`AB_HS_NORESTART])
      else $error("high-speed no restart flag missing");
   AST_STARTBYTE_NO_RESTART: assert property (cmdPush && !restartEnable && cmdStartByte
                              |=> abortFlags[`AB_SB_NORESTART])
      else $error("start byte no restart flag missing");
   AST_MARB: assert property (sclRise && masterTx && masterSdaRelease && !sdaLine
                              |=> abortFlags[`AB_ARB_LOST])
      else $error("master arbitration loss flag missing");
   // A master-only loss must not be reported as a slave loss
   AST_SLV_ONLY: assert property (!sArb && !abortFlags[`AB_SLV_ARB_LOST]
                                  && !(regWr && selAbort) |=> !abortFlags[`AB_SLV_ARB_LOST])
      else $error("slave arbitration flag set without slave loss");

   COV_NACK: cover property (ackSlot && sdaLine && masterTx);
   COV_SARB: cover property (sArb);
   COV_TO:   cover property (masterTimeoutReset);
   COV_CLR:  cover property (abortActive ##1 regWr && selAbort ##1 !abortActive);
   COV_GCR:  cover property (evGcRd);

endmodule : i2c_transmit_abort_status
`default_nettype wire

// ### i2c_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Remote bus party
// ----------------------------------------------------------------
module i2c_bus_model (
   output var logic scl,
   output var logic sda
);
   // Both lines rest at the pull-up level, clock still between frames
   initial begin
      scl = 1'b1;
      sda = 1'b1;
   end
   // START, eight bits at bitLvl, ack slot at ackLvl; SCL left low
   task automatic frame(input logic bitLvl, input logic ackLvl);
      #1 sda = 1'b0;
      #80 scl = 1'b0;
      for (int i = 0; i < 9; i++) begin
         #40 sda = (i == 8) ? ackLvl : bitLvl;
         #40 scl = 1'b1;
         #80 scl = 1'b0;
      end
   endtask : frame
   task automatic stop();
      #40 sda = 1'b0;
      #40 scl = 1'b1;
      #80 sda = 1'b1;
      #80;
   endtask : stop
   // Slow slave holding the clock low
   task automatic stretch(input int ns);
      #1 scl = 1'b0;
      #(ns) scl = 1'b1;
   endtask : stretch
endmodule : i2c_bus_model
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "i2c_abort_defs.svh"
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin bad_count++; \
   $display("mismatch %0t got %h exp %h", $time, (a), (e)); end end
module tb_top;
   import i2c_abort_pkg::*;
   logic [7:0]  regAddr;
   logic [31:0] regWrData, regRdData, d;
   logic [2:0]  byteKind;
   logic ref_clk, rst_n, regWr, regRd, sclIn, sdaIn, masterEnable, restartEnable;
   logic tenBitMode, hsMode, cmdPush, cmdRead, cmdStartByte, masterTx;
   logic masterSdaRelease, masterSclRelease, slaveTx, slaveSdaRelease, slaveReadReq;
   logic txFifoNotEmpty, txHeadIsRead, abortActive, masterTimeoutReset;
   int   bad_count, tests_run, n;
   i2c_transmit_abort_status u_dut (.ref_clk, .rst_n, .regAddr, .regWrData, .regWr,
      .regRd, .regRdData, .sclIn, .sdaIn, .masterEnable, .restartEnable, .tenBitMode,
      .hsMode, .cmdPush, .cmdRead, .cmdStartByte, .byteKind, .masterTx,
      .masterSdaRelease, .masterSclRelease, .slaveTx, .slaveSdaRelease, .slaveReadReq,
      .txFifoNotEmpty, .txHeadIsRead, .abortActive, .masterTimeoutReset);
   i2c_bus_model u_bus (.scl(sclIn), .sda(sdaIn));
   // ----------------------------------------------------------------
   // Access tasks
   // ----------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge ref_clk);
      regAddr <= a; regWrData <= v; regWr <= 1'b1;
      @(posedge ref_clk);
      regWr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge ref_clk);
      regAddr <= a; regRd <= 1'b1;
      @(posedge ref_clk);
      regRd <= 1'b0;
      #1 d = regRdData;
   endtask : rd
   // Read and compare the flags, then clear them as software must
   task automatic flags(input logic [31:0] e);
      repeat (4) @(posedge ref_clk);
      rd(`ABORT_CAUSE_OFS);
      `CHK(d, e)
      `CHK(abortActive, |e)
      wr(`ABORT_CAUSE_OFS, 32'h0);
      repeat (2) @(posedge ref_clk);
      #1 `CHK(abortActive, 1'b0)
   endtask : flags
   task automatic push(input logic r, input logic s);
      @(posedge ref_clk);
      cmdPush <= 1'b1; cmdRead <= r; cmdStartByte <= s;
      @(posedge ref_clk);
      cmdPush <= 1'b0; cmdRead <= 1'b0; cmdStartByte <= 1'b0;
   endtask : push
   task automatic slvReq();
      @(posedge ref_clk);
      slaveReadReq <= 1'b1;
      @(posedge ref_clk);
      slaveReadReq <= 1'b0;
   endtask : slvReq
   task automatic results();
      if (bad_count == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : results
   // ----------------------------------------------------------------
   // Clock and watchdog
   // ----------------------------------------------------------------
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   // Bounds a hang well past the expected run of some 20 us
   initial begin
      #200us;
      bad_count++;
      results();
   end
   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial begin
      {regAddr, regWrData, byteKind} = {8'h00, 32'h0, 3'h7};
      {rst_n, regWr, regRd, tenBitMode, hsMode, cmdPush, cmdRead, cmdStartByte} = 8'h00;
      {masterTx, masterSdaRelease, masterSclRelease, slaveTx, slaveSdaRelease} = 5'h00;
      {slaveReadReq, txFifoNotEmpty, txHeadIsRead} = 3'h0;
      {masterEnable, restartEnable, bad_count, tests_run} = {2'b11, 64'h0};
      repeat (8) @(posedge ref_clk);
      rst_n <= 1'b1;
      rd(`ABORT_CAUSE_OFS); `CHK(d, 32'h0)
      rd(`TIMEOUT_CTRL_OFS); `CHK(d, 32'h0)
      wr(8'h84, 32'hffffffff); rd(8'h84); `CHK(d, 32'h0)
      wr(`ABORT_CAUSE_OFS, 32'hffffffff); flags(32'h0000ffff);
      masterTx <= 1'b1;
      // Kinds 0..4 map onto flag bits 0..4 when the ack slot stays high
      for (int k = 0; k < 5; k++) begin
         byteKind <= 3'(k);
         u_bus.frame(1'b1, 1'b1); u_bus.stop();
         flags(32'h1 << k);
      end
      byteKind <= KIND_STARTB; u_bus.frame(1'b1, 1'b0); u_bus.stop();
      flags(32'h1 << `AB_SB_ACKED);
      hsMode <= 1'b1; byteKind <= KIND_HSCODE; u_bus.frame(1'b1, 1'b0); u_bus.stop();
      flags(32'h1 << `AB_HS_ACKED);
      hsMode <= 1'b0; byteKind <= KIND_GENCALL; u_bus.frame(1'b1, 1'b0);
      push(1'b1, 1'b0); u_bus.stop();
      flags(32'h1 << `AB_GENCALL_READ);
      byteKind <= KIND_NONE; masterTx <= 1'b0;
      push(1'b0, 1'b1); flags(32'h0);
      restartEnable <= 1'b0;
      push(1'b0, 1'b1); flags(32'h1 << `AB_SB_NORESTART);
      tenBitMode <= 1'b1; push(1'b1, 1'b0);
      flags(32'h1 << `AB_TENRD_NORESTART);
      tenBitMode <= 1'b0; hsMode <= 1'b1; push(1'b0, 1'b0);
      flags(32'h1 << `AB_HS_NORESTART);
      {hsMode, restartEnable, masterEnable} <= 3'b010; push(1'b0, 1'b0);
      flags(32'h1 << `AB_MASTER_DIS);
      masterEnable <= 1'b1; txFifoNotEmpty <= 1'b1; slvReq();
      flags(32'h1 << `AB_SLV_FLUSH);
      txHeadIsRead <= 1'b1; slvReq();
      flags(32'h1 << `AB_SLV_REQ_TX | 32'h1 << `AB_SLV_FLUSH);
      {txFifoNotEmpty, txHeadIsRead} <= 2'b00;
      {masterTx, masterSdaRelease} <= 2'b11; u_bus.frame(1'b0, 1'b1); u_bus.stop();
      {masterTx, masterSdaRelease} <= 2'b00; flags(32'h1 << `AB_ARB_LOST);
      {slaveTx, slaveSdaRelease} <= 2'b11; u_bus.frame(1'b0, 1'b1); u_bus.stop();
      {slaveTx, slaveSdaRelease} <= 2'b00; flags(32'h5000);
      wr(`TIMEOUT_CTRL_OFS, 32'h1); rd(`TIMEOUT_CTRL_OFS); `CHK(d, 32'h1)
      {masterTx, masterSclRelease} <= 2'b11;
      fork
         u_bus.stretch(1400);
         begin
            n = 0;
            while (masterTimeoutReset !== 1'b1 && n < 400) begin
               @(posedge ref_clk);
               #1 n++;
            end
         end
      join
      `CHK(n >= 256 && n <= 262, 1'b1)
      {masterTx, masterSclRelease} <= 2'b00;
      results();
   end
endmodule : tb_top
`default_nettype wire
